// ---- inc/dsc_pkg.sv ----
/*
  Shared types and constants of the disk sector cache controller.
  Assumes one drive clock domain; sectors are counted, not bytes.
*/
// Summary of operation
// - Partial read hit starts host transfer from the buffer; the rest comes from media
// - A partially hit read never starts read-ahead afterwards
// - Host pointer at hit data, disk pointer just after it
// - Hit sectors go to the host while missing sectors are read
// - Cached write completes with a good interrupt once all sectors are received
// - Sequential write during recording continues without a rotational search
// - Sequential write after recording has ended searches normally
// - Non-sequential write is taken now and recorded after the previous one
// - Reset or cache disable waits until every pending sector is recorded
// - Read of just-written sectors is served from write data, no media read
// - Unrecovered write error skips that sector and records the remainder
// - After a cached write error the next non-write command is refused with error status
// - A write after error processing is recorded first, then the error reported
// - A failed recovery clears write cache enable until the host sets it again
// - Write cache enable comes back enabled after every power-up
// - Only the three write commands use posted write caching
// - A sector reassigned successfully raises no error
`default_nettype none
package dsc_pkg;
  localparam int LBA_W = 28;
  localparam int CNT_W = 8;
  localparam int PTR_W = 9;
  localparam int REM_W = 10;
  localparam int DATA_W = 16;
  localparam int FIFO_DEPTH = 16;
  localparam logic [PTR_W-1:0] RC_SEG_BASE = 9'h000;
  localparam logic [PTR_W-1:0] WC_SEG_BASE = 9'h100;
  localparam logic WCE_RESET = 1'h1;

  typedef enum logic [2:0] {
    OP_RD_PIO = 3'h0, OP_RD_MUL = 3'h1, OP_RD_DMA = 3'h2,
    OP_WR_PIO = 3'h4, OP_WR_MUL = 3'h5, OP_WR_DMA = 3'h6, OP_OTHER = 3'h7
  } dsc_op_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1, ST_READ = 4'h2, ST_WRRX = 4'h4, ST_WRWAIT = 4'h8
  } dsc_state_t;

  typedef struct packed {
    dsc_op_t          op;
    logic [LBA_W-1:0] lba;
    logic [CNT_W-1:0] cnt;
  } dsc_cmd_t;

  typedef struct packed {
    logic             wr;
    logic             seek;
    logic [LBA_W-1:0] lba;
    logic [CNT_W-1:0] cnt;
  } dsc_med_t;

  typedef struct packed {
    logic             err;
    logic [LBA_W-1:0] lba;
  } dsc_err_t;

  typedef struct packed {
    logic             valid;
    logic [LBA_W-1:0] base;
    logic [CNT_W-1:0] cnt;
    logic [PTR_W-1:0] addr;
  } dsc_seg_t;

  function automatic logic isWrite(input dsc_op_t op);
    isWrite = (op == OP_WR_PIO) || (op == OP_WR_MUL) || (op == OP_WR_DMA);
  endfunction : isWrite

  function automatic logic isRead(input dsc_op_t op);
    isRead = (op == OP_RD_PIO) || (op == OP_RD_MUL) || (op == OP_RD_DMA);
  endfunction : isRead
endpackage : dsc_pkg
`default_nettype wire

// ---- hdl/dsc_fifo.sv ----
/*
  Write data FIFO between host and media.
  Assumes both sides share clk; ce freezes all state.
*/
`timescale 1ns/1ns
`default_nettype none
module dsc_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 16
) (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic         ce,
  input  wire logic         inValid,
  output logic              inReady,
  input  wire logic [W-1:0] inData,
  output logic              outValid,
  input  wire logic         outReady,
  output logic [W-1:0]      outData
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wrPtr_q;
  logic [AW:0]  wrPtr_d;
  logic [AW:0]  rdPtr_q;
  logic [AW:0]  rdPtr_d;
  logic         push;
  logic         pop;

  always_comb
  begin
    inReady  = ce && !((wrPtr_q[AW] != rdPtr_q[AW]) && (wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]));
    outValid = ce && (wrPtr_q != rdPtr_q);
    outData  = mem[rdPtr_q[AW-1:0]];
    push     = inValid && inReady;
    pop      = outValid && outReady;
    wrPtr_d  = push ? wrPtr_q + 1'b1 : wrPtr_q;
    rdPtr_d  = pop ? rdPtr_q + 1'b1 : rdPtr_q;
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end
    else if (ce)
    begin
      wrPtr_q <= wrPtr_d;
      rdPtr_q <= rdPtr_d;
    end
  end

  always_ff @(posedge clk)
  begin
    if (ce && push)
      mem[wrPtr_q[AW-1:0]] <= inData;
  end
endmodule : dsc_fifo
`default_nettype wire

// ---- hdl/dsc_hit_check.sv ----
/*
  Compares a requested sector range with one buffered segment.
  Assumes the segment record is stable during the compare.
*/
`timescale 1ns/1ns
`default_nettype none
module dsc_hit_check (
  input  wire logic [dsc_pkg::LBA_W-1:0] lba,
  input  wire logic [dsc_pkg::CNT_W-1:0] cnt,
  input  wire dsc_pkg::dsc_seg_t         seg,
  output logic                           leadHit,
  output logic                           fullHit,
  output logic [dsc_pkg::PTR_W-1:0]      hitCnt,
  output logic [dsc_pkg::PTR_W-1:0]      hitAddr
);
  logic [dsc_pkg::LBA_W-1:0] off;
  logic [dsc_pkg::CNT_W-1:0] avail;

  always_comb
  begin
    off     = lba - seg.base;
    avail   = seg.cnt - off[dsc_pkg::CNT_W-1:0];
    leadHit = seg.valid && (lba >= seg.base) && (off < {20'h0, seg.cnt});
    fullHit = leadHit && (cnt <= avail);
    hitCnt  = {1'h0, (fullHit ? cnt : avail)};
    hitAddr = seg.addr + off[dsc_pkg::PTR_W-1:0];
  end
endmodule : dsc_hit_check
`default_nettype wire

// ---- hdl/dsc_cache_ctrl.sv ----
/*
  Sector cache control: read hits, posted writes, deferred errors.
  Assumes a media engine that takes commands, pulls write words one
  per sector and reports each sector done, failed or reassigned.
*/
`timescale 1ns/1ns
`default_nettype none
module dsc_cache_ctrl (
  input  wire logic                      clk,
  input  wire logic                      resetn,
  input  wire logic                      ce,
  input  wire logic                      cmdValid,
  input  wire dsc_pkg::dsc_cmd_t         cmd,
  output logic                           cmdReady,
  input  wire logic                      hostWrValid,
  input  wire logic [dsc_pkg::DATA_W-1:0] hostWrData,
  output logic                           hostWrReady,
  output logic                           hostXferStart,
  input  wire logic                      hostXferDone,
  output logic [dsc_pkg::PTR_W-1:0]      hostBufferPointer,
  output logic [dsc_pkg::PTR_W-1:0]      diskBufferPointer,
  output logic                           irq,
  output dsc_pkg::dsc_err_t              endStatus,
  output logic                           medCmdValid,
  output dsc_pkg::dsc_med_t              medCmd,
  input  wire logic                      medCmdReady,
  output logic                           medWrValid,
  output logic [dsc_pkg::DATA_W-1:0]     medWrData,
  input  wire logic                      medWrReady,
  input  wire logic                      medSecDone,
  input  wire logic                      medSecErr,
  input  wire logic                      medReassigned,
  input  wire logic                      rstReq,
  input  wire logic                      wcDisReq,
  input  wire logic                      wcEnReq,
  output logic                           rstAck,
  output logic                           wceOut
);
  dsc_pkg::dsc_state_t           st_q, st_d;
  dsc_pkg::dsc_cmd_t             cmd_q, cmd_d;
  dsc_pkg::dsc_med_t             mc_q, mc_d, qc_q, qc_d;
  dsc_pkg::dsc_err_t             err_q, err_d, stat_q, stat_d;
  dsc_pkg::dsc_seg_t             wcSeg_q, wcSeg_d, rcSeg_q, rcSeg_d;
  logic [dsc_pkg::REM_W-1:0]     rem_q, rem_d;
  logic [dsc_pkg::CNT_W:0]       rx_q, rx_d;
  logic [dsc_pkg::LBA_W-1:0]     end_q, end_d, cur_q, cur_d;
  logic [dsc_pkg::PTR_W-1:0]     hbp_q, hbp_d, dbp_q, dbp_d;
  logic                          mcv_q, mcv_d, qv_q, qv_d, wce_q, wce_d;
  logic                          curWr_q, curWr_d, hostDone_q, hostDone_d;
  logic                          irq_q, irq_d, xs_q, xs_d;
  logic                          rstPend_q, rstPend_d, dis_q, dis_d;
  logic                          wrBusy, errSet, rxTake, fifoInRdy;
  logic                          rcLead, rcFull, wcLead, wcFull;
  logic [dsc_pkg::PTR_W-1:0]     rcCnt, rcAddr, wcCnt, wcAddr;

  dsc_hit_check u_rcHit (
    .lba     (cmd.lba),
    .cnt     (cmd.cnt),
    .seg     (rcSeg_q),
    .leadHit (rcLead),
    .fullHit (rcFull),
    .hitCnt  (rcCnt),
    .hitAddr (rcAddr)
  );

  dsc_hit_check u_wcHit (
    .lba     (cmd.lba),
    .cnt     (cmd.cnt),
    .seg     (wcSeg_q),
    .leadHit (wcLead),
    .fullHit (wcFull),
    .hitCnt  (wcCnt),
    .hitAddr (wcAddr)
  );

  dsc_fifo #(.W(dsc_pkg::DATA_W), .DEPTH(dsc_pkg::FIFO_DEPTH)) u_fifo (
    .clk      (clk),
    .resetn   (resetn),
    .ce       (ce),
    .inValid  (rxTake),
    .inReady  (fifoInRdy),
    .inData   (hostWrData),
    .outValid (medWrValid),
    .outReady (medWrReady),
    .outData  (medWrData)
  );

  always_comb
  begin
    // Pending-write flag
    // busy while unrecorded
    wrBusy      = (rem_q != '0) || qv_q || mcv_q;
    hostWrReady = ce && (st_q == dsc_pkg::ST_WRRX) && (rx_q < {1'h0, cmd_q.cnt}) && fifoInRdy;
    rxTake      = hostWrReady && hostWrValid;
    cmdReady    = ce && (st_q == dsc_pkg::ST_IDLE) && !rstPend_q && !dis_q && !mcv_q;
    if (dsc_pkg::isWrite(cmd.op) && qv_q)
      cmdReady = 1'h0;
    if (dsc_pkg::isRead(cmd.op) && !err_q.err && wrBusy && !wcFull)
      cmdReady = 1'h0;
    rstAck      = ce && (st_q == dsc_pkg::ST_IDLE) && rstPend_q && !wrBusy;
  end

  always_comb
  begin
    st_d = st_q;  cmd_d = cmd_q;  mc_d = mc_q;  qc_d = qc_q;  err_d = err_q;
    stat_d = stat_q;  wcSeg_d = wcSeg_q;  rcSeg_d = rcSeg_q;  rem_d = rem_q;
    rx_d = rx_q;  end_d = end_q;  cur_d = cur_q;  hbp_d = hbp_q;  dbp_d = dbp_q;
    mcv_d = mcv_q;  qv_d = qv_q;  wce_d = wce_q;  curWr_d = curWr_q;
    hostDone_d = hostDone_q;  irq_d = 1'h0;  xs_d = 1'h0;
    dis_d = dis_q || wcDisReq;
    rstPend_d = rstReq || (rstPend_q && !rstAck);
    if (wcEnReq)
      wce_d = 1'h1;
    if (mcv_q && medCmdReady)
      mcv_d = 1'h0;
    if ((medSecDone || medSecErr) && (rem_q != '0))
    begin
      rem_d = rem_q - 1'b1;
      cur_d = cur_q + 1'b1;
    end
    errSet = medSecErr && curWr_q && !medReassigned;
    if (errSet)
    begin
      err_d = '{err: 1'h1, lba: cur_q};
      wce_d = 1'h0;
    end
    if (qv_q && (rem_d == '0) && !mcv_q)
    begin
      mc_d = qc_q;
      mcv_d = 1'h1;
      qv_d = 1'h0;
      rem_d = {2'h0, qc_q.cnt};
      cur_d = qc_q.lba;
      curWr_d = 1'h1;
    end
    if (rstAck)
    begin
      wcSeg_d.valid = 1'h0;
      rcSeg_d.valid = 1'h0;
    end
    if (dis_q && !wrBusy && (st_q == dsc_pkg::ST_IDLE))
    begin
      wce_d = 1'h0;
      dis_d = wcDisReq;
      wcSeg_d.valid = 1'h0;
    end
    case (st_q)
      dsc_pkg::ST_IDLE:
      begin
        if (cmdValid && cmdReady)
        begin
          cmd_d = cmd;
          if (err_q.err && !dsc_pkg::isWrite(cmd.op))
          begin
            irq_d = 1'h1;
            stat_d = err_q;
            if (!errSet)
              err_d.err = 1'h0;
          end
          else if (dsc_pkg::isWrite(cmd.op))
          begin
            st_d = dsc_pkg::ST_WRRX;
            rx_d = '0;
            wcSeg_d = '{valid: 1'h1, base: cmd.lba, cnt: cmd.cnt, addr: dsc_pkg::WC_SEG_BASE};
            rcSeg_d.valid = 1'h0;
            end_d = cmd.lba + {20'h0, cmd.cnt};
            curWr_d = 1'h1;
            if ((cmd.lba == end_q) && (rem_q != '0))
            begin
              mc_d = '{wr: 1'h1, seek: 1'h0, lba: cmd.lba, cnt: cmd.cnt};
              mcv_d = 1'h1;
              rem_d = rem_d + {2'h0, cmd.cnt};
            end
            else if (!wrBusy)
            begin
              mc_d = '{wr: 1'h1, seek: 1'h1, lba: cmd.lba, cnt: cmd.cnt};
              mcv_d = 1'h1;
              rem_d = {2'h0, cmd.cnt};
              cur_d = cmd.lba;
            end
            else
            begin
              qv_d = 1'h1;
              qc_d = '{wr: 1'h1, seek: 1'h1, lba: cmd.lba, cnt: cmd.cnt};
            end
          end
          else if (dsc_pkg::isRead(cmd.op))
          begin
            st_d = dsc_pkg::ST_READ;
            xs_d = 1'h1;
            if (wcFull)
            begin
              hbp_d = wcAddr;
              dbp_d = wcAddr + wcCnt;
            end
            else if (rcLead)
            begin
              hbp_d = rcAddr;
              dbp_d = rcAddr + rcCnt;
              if (!rcFull)
              begin
                mc_d = '{wr: 1'h0, seek: 1'h1, lba: cmd.lba + {19'h0, rcCnt},
                         cnt: cmd.cnt - rcCnt[dsc_pkg::CNT_W-1:0]};
                mcv_d = 1'h1;
                rem_d = {2'h0, cmd.cnt - rcCnt[dsc_pkg::CNT_W-1:0]};
                curWr_d = 1'h0;
              end
            end
            else
            begin
              hbp_d = dsc_pkg::RC_SEG_BASE;
              dbp_d = dsc_pkg::RC_SEG_BASE;
              mc_d = '{wr: 1'h0, seek: 1'h1, lba: cmd.lba, cnt: cmd.cnt};
              mcv_d = 1'h1;
              rem_d = {2'h0, cmd.cnt};
              curWr_d = 1'h0;
            end
          end
          else
          begin
            irq_d = 1'h1;
            stat_d = '0;
            wcSeg_d.valid = 1'h0;
            rcSeg_d.valid = 1'h0;
          end
        end
      end
      dsc_pkg::ST_READ:
      begin
        hostDone_d = hostDone_q || hostXferDone;
        if (hostDone_d && (rem_q == '0) && !mcv_q)
        begin
          irq_d = 1'h1;
          stat_d = '0;
          hostDone_d = 1'h0;
          st_d = dsc_pkg::ST_IDLE;
          rcSeg_d = '{valid: 1'h1, base: cmd_q.lba, cnt: cmd_q.cnt, addr: hbp_q};
        end
      end
      dsc_pkg::ST_WRRX:
      begin
        if (rxTake)
          rx_d = rx_q + 1'b1;
        if (rx_d == {1'h0, cmd_q.cnt})
        begin
          if (wce_q && !err_q.err)
          begin
            irq_d = 1'h1;
            stat_d = '0;
            st_d = dsc_pkg::ST_IDLE;
          end
          else
            st_d = dsc_pkg::ST_WRWAIT;
        end
      end
      dsc_pkg::ST_WRWAIT:
      begin
        if (!wrBusy)
        begin
          irq_d = 1'h1;
          stat_d = err_q;
          if (!errSet)
            err_d.err = 1'h0;
          st_d = dsc_pkg::ST_IDLE;
        end
      end
      default:
        st_d = dsc_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      st_q <= dsc_pkg::ST_IDLE;  cmd_q <= '0;  mc_q <= '0;  qc_q <= '0;
      err_q <= '0;  stat_q <= '0;  wcSeg_q <= '0;  rcSeg_q <= '0;  rem_q <= '0;
      rx_q <= '0;  end_q <= '0;  cur_q <= '0;  hbp_q <= '0;  dbp_q <= '0;
      mcv_q <= 1'h0;  qv_q <= 1'h0;  curWr_q <= 1'h0;  hostDone_q <= 1'h0;
      wce_q <= dsc_pkg::WCE_RESET;
      irq_q <= 1'h0;  xs_q <= 1'h0;  rstPend_q <= 1'h0;  dis_q <= 1'h0;
    end
    else if (ce)
    begin
      st_q <= st_d;  cmd_q <= cmd_d;  mc_q <= mc_d;  qc_q <= qc_d;
      err_q <= err_d;  stat_q <= stat_d;  wcSeg_q <= wcSeg_d;  rcSeg_q <= rcSeg_d;
      rem_q <= rem_d;  rx_q <= rx_d;  end_q <= end_d;  cur_q <= cur_d;
      hbp_q <= hbp_d;  dbp_q <= dbp_d;  mcv_q <= mcv_d;  qv_q <= qv_d;
      wce_q <= wce_d;  curWr_q <= curWr_d;  hostDone_q <= hostDone_d;
      irq_q <= irq_d;  xs_q <= xs_d;  rstPend_q <= rstPend_d;  dis_q <= dis_d;
    end
  end

  assign hostBufferPointer = hbp_q;
  assign diskBufferPointer = dbp_q;
  assign irq               = irq_q;
  assign hostXferStart     = xs_q;
  assign endStatus         = stat_q;
  assign medCmdValid       = mcv_q;
  assign medCmd            = mc_q;
  assign wceOut            = wce_q;

  property p_earlyDone;
    @(posedge clk) disable iff (!resetn)
    (ce && st_q == dsc_pkg::ST_WRRX && rx_d == {1'h0, cmd_q.cnt} && wce_q && !err_q.err)
      |=> (irq && !endStatus.err && st_q == dsc_pkg::ST_IDLE);
  endproperty
  a_earlyDone: assert property (p_earlyDone) else $error("No early completion");

  property p_refuse;
    @(posedge clk) disable iff (!resetn)
    (cmdValid && cmdReady && err_q.err && !dsc_pkg::isWrite(cmd.op))
      |=> (irq && endStatus.err && st_q == dsc_pkg::ST_IDLE);
  endproperty
  a_refuse: assert property (p_refuse) else $error("Stored error not reported");

  property p_drainFirst;
    @(posedge clk) disable iff (!resetn)
    rstAck |-> (!medWrValid && !medCmdValid && (rem_q == '0) && !qv_q);
  endproperty
  a_drainFirst: assert property (p_drainFirst) else $error("Reset acted while busy");

  property p_selfDisable;
    @(posedge clk) disable iff (!resetn)
    (ce && medSecErr && curWr_q && !medReassigned) |=> (!wceOut && err_q.err);
  endproperty
  a_selfDisable: assert property (p_selfDisable) else $error("Cache not disabled");

  property p_reassignQuiet;
    @(posedge clk) disable iff (!resetn)
    (ce && medSecErr && medReassigned && !err_q.err) |=> !err_q.err;
  endproperty
  a_reassignQuiet: assert property (p_reassignQuiet) else $error("Reassign flagged");

  property p_pointers;
    @(posedge clk) disable iff (!resetn)
    (cmdValid && cmdReady && !err_q.err && dsc_pkg::isRead(cmd.op) && !wcFull && rcLead)
      |=> (diskBufferPointer == hostBufferPointer + $past(rcCnt)) && hostXferStart;
  endproperty
  a_pointers: assert property (p_pointers) else $error("Partial hit pointers");

  property p_noSearch;
    @(posedge clk) disable iff (!resetn)
    (cmdValid && cmdReady && !err_q.err && dsc_pkg::isWrite(cmd.op) && cmd.lba == end_q
      && rem_q != '0) |=> (medCmdValid && !medCmd.seek && medCmd.wr);
  endproperty
  a_noSearch: assert property (p_noSearch) else $error("Sequential write searched");

  property p_wcRead;
    @(posedge clk) disable iff (!resetn)
    (cmdValid && cmdReady && !err_q.err && dsc_pkg::isRead(cmd.op) && wcFull)
      |=> !(medCmdValid && !medCmd.wr) [*2];
  endproperty
  a_wcRead: assert property (p_wcRead) else $error("Media read on write hit");
endmodule : dsc_cache_ctrl
`default_nettype wire

// ---- verification/dsc_media_model.sv ----
/*
  Media engine model facing the cache controller's media port.
  Assumes one clk; sector time and error kind set by the bench.
*/
`timescale 1ns/1ns
`default_nettype none
module dsc_media_model (
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic [15:0]       delay,
  input  wire logic [1:0]        errMode,
  input  wire logic              medCmdValid,
  input  wire dsc_pkg::dsc_med_t medCmd,
  output logic                   medCmdReady,
  input  wire logic              medWrValid,
  output logic                   medWrReady,
  output logic                   medSecDone,
  output logic                   medSecErr,
  output logic                   medReassigned
);
  logic [9:0]  rem;
  logic        wrMode;
  logic        haveWord;
  logic [15:0] t;
  logic        fin;
  assign medCmdReady = 1'b1;
  assign medWrReady  = wrMode && (rem != 10'h000) && !haveWord;
  assign fin = (rem != 10'h000) && (!wrMode || haveWord) && (t >= delay);
  // Sector finish: good, failed or healed
  always @(posedge clk)
  begin
    medSecDone    <= fin && (errMode == 2'h0);
    medSecErr     <= fin && (errMode != 2'h0);
    medReassigned <= fin && (errMode == 2'h2);
    t             <= (fin || rem == 10'h000) ? 16'h0000 : t + 16'h0001;
    haveWord      <= fin ? 1'b0 : (haveWord || (medWrValid && medWrReady));
    rem <= rem - {9'h000, fin} + (medCmdValid ? {2'h0, medCmd.cnt} : 10'h000);
    if (medCmdValid)
      wrMode <= medCmd.wr;
    if (!resetn)
    begin
      rem      <= 10'h000;
      haveWord <= 1'b0;
      wrMode   <= 1'b0;
    end
  end
endmodule : dsc_media_model
`default_nettype wire

// ---- verification/tb_top.sv ----
/*
  Self-checking bench of the sector cache controller.
  Assumes the media model above; inputs move at the falling edge, except errMode, cleared at the rising edge.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic                   clk = 1'b0;
  logic                   resetn = 1'b0;
  logic                   cmdValid = 1'b0;
  dsc_pkg::dsc_cmd_t      cmd = '0;
  logic                   hostWrValid = 1'b0;
  logic [15:0]            hostWrData = 16'h0000;
  logic                   hostXferDone = 1'b0;
  logic                   rstReq = 1'b0;
  logic                   wcEnReq = 1'b0;
  logic                   wcDisReq = 1'b0;
  logic [15:0]            delay = 16'h0002;
  logic [1:0]             errMode = 2'h0;
  logic                   cmdReady, hostWrReady, hostXferStart, irq, rstAck, wceOut;
  logic                   medCmdValid, medCmdReady, medWrValid, medWrReady;
  logic                   medSecDone, medSecErr, medReassigned, stalled;
  logic [8:0]             hostBufferPointer, diskBufferPointer;
  logic [15:0]            medWrData;
  dsc_pkg::dsc_err_t      endStatus;
  dsc_pkg::dsc_med_t      medCmd, lastMed;
  int                     n_mismatch = 0;
  int                     tests_run = 0;
  int                     nMed = 0;
  int                     nDone = 0;
  int                     nWord = 0;
  int                     nPull = 0;
  always #4 clk = ~clk;
  dsc_cache_ctrl dsc_cache_ctrl_i (.clk, .resetn, .ce(1'b1), .cmdValid, .cmd, .cmdReady,
    .hostWrValid, .hostWrData, .hostWrReady, .hostXferStart, .hostXferDone,
    .hostBufferPointer, .diskBufferPointer, .irq, .endStatus, .medCmdValid, .medCmd,
    .medCmdReady, .medWrValid, .medWrData, .medWrReady, .medSecDone, .medSecErr,
    .medReassigned, .rstReq, .wcDisReq, .wcEnReq, .rstAck, .wceOut);
  dsc_media_model dsc_media_model_i (.clk, .resetn, .delay, .errMode, .medCmdValid,
    .medCmd, .medCmdReady, .medWrValid, .medWrReady, .medSecDone, .medSecErr,
    .medReassigned);
  // Media traffic log
  always @(posedge clk)
  begin
    if (medCmdValid && medCmdReady)
    begin
      nMed++;
      lastMed = medCmd;
    end
    if (medSecDone || medSecErr)
      nDone++;
    if (medSecErr)
      errMode <= 2'h0;
    if (medWrValid && medWrReady)
    begin
      check("medWrData", medWrData, 16'(nPull));
      nPull++;
    end
  end
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict
  task automatic hang;
    n_mismatch++;
    $display("wrong value wait expected event seen none");
    give_verdict();
  endtask : hang
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic waitIrq;
    int i;
    for (i = 0; i < 3000 && irq !== 1'b1; i++) @(negedge clk);
    if (irq !== 1'b1) hang();
  endtask : waitIrq
  task automatic waitDone(input int n);
    int i;
    for (i = 0; i < 3000 && nDone < n; i++) @(negedge clk);
    if (nDone < n) hang();
  endtask : waitDone
  task automatic issue(input dsc_pkg::dsc_op_t op, input logic [27:0] lba,
                       input logic [7:0] cnt);
    int i;
    cmd = '{op: op, lba: lba, cnt: cnt};
    cmdValid = 1'b1;
    #1;
    for (i = 0; i < 3000 && cmdReady !== 1'b1; i++) @(negedge clk);
    if (cmdReady !== 1'b1) hang();
    @(negedge clk);
    cmdValid = 1'b0;
  endtask : issue
  task automatic send(input int n);
    int i;
    int k;
    stalled = 1'b0;
    hostWrValid = 1'b1;
    for (k = 0; k < n; k++)
    begin
      hostWrData = 16'(nWord);
      for (i = 0; i < 3000 && hostWrReady !== 1'b1; i++) @(negedge clk);
      if (hostWrReady !== 1'b1) hang();
      stalled = stalled | (i != 0);
      @(negedge clk);
      nWord++;
    end
    hostWrValid = 1'b0;
  endtask : send
  task automatic xfer(output int s);
    int i;
    for (i = 0; i < 3000 && hostXferStart !== 1'b1; i++) @(negedge clk);
    if (hostXferStart !== 1'b1) hang();
    s = nDone;
    @(negedge clk);
    hostXferDone = 1'b1;
    @(negedge clk);
    hostXferDone = 1'b0;
  endtask : xfer
  // posted and appended writes, FIFO filled
  task automatic t_post;
    delay = 16'h0014;
    issue(dsc_pkg::OP_WR_MUL, 28'h0000064, 8'h14);
    send(20);
    waitIrq();
    check("endStatus.err", endStatus.err, 1'b0);
    check("still recording", nDone < 20, 1'b1);
    check("first seek", lastMed.seek, 1'b1);
    check("fifo refused", stalled, 1'b1);
    issue(dsc_pkg::OP_WR_PIO, 28'h0000078, 8'h02);
    send(2);
    waitIrq();
    check("append seek", lastMed.seek, 1'b0);
    check("append lba", lastMed.lba, 28'h0000078);
  endtask : t_post
  // reset drain, search, read from write data
  task automatic t_drain;
    int s;
    int m;
    rstReq = 1'b1;
    @(negedge clk);
    rstReq = 1'b0;
    for (s = 0; s < 3000 && rstAck !== 1'b1; s++) @(negedge clk);
    if (rstAck !== 1'b1) hang();
    check("recorded at reset", nDone, 22);
    issue(dsc_pkg::OP_WR_DMA, 28'h000007a, 8'h01);
    send(1);
    waitIrq();
    check("idle seek", lastMed.seek, 1'b1);
    waitDone(23);
    m = nMed;
    issue(dsc_pkg::OP_RD_PIO, 28'h000007a, 8'h01);
    xfer(s);
    waitIrq();
    check("no media read", nMed, m);
  endtask : t_drain
  task automatic t_partial;
    int s;
    int d;
    int m;
    delay = 16'h0004;
    issue(dsc_pkg::OP_RD_DMA, 28'h00000c8, 8'h02);
    xfer(s);
    waitIrq();
    d = nDone;
    m = nMed;
    issue(dsc_pkg::OP_RD_MUL, 28'h00000c9, 8'h03);
    xfer(s);
    check("host ptr", hostBufferPointer, dsc_pkg::RC_SEG_BASE + 9'h001);
    check("disk ptr", diskBufferPointer, dsc_pkg::RC_SEG_BASE + 9'h002);
    check("miss lba", lastMed.lba, 28'h00000ca);
    check("miss cnt", lastMed.cnt, 8'h02);
    check("overlap", (s - d) < 2, 1'b1);
    waitIrq();
    repeat (40) @(negedge clk);
    check("no read-ahead", nMed, m + 1);
  endtask : t_partial
  task automatic t_error;
    int d;
    int m;
    errMode = 2'h2;
    issue(dsc_pkg::OP_WR_DMA, 28'h000012c, 8'h01);
    send(1);
    waitIrq();
    waitDone(nDone + 1);
    m = nMed;
    issue(dsc_pkg::OP_OTHER, 28'h0000000, 8'h00);
    waitIrq();
    check("healed err", endStatus.err, 1'b0);
    check("other not posted", nMed, m);
    errMode = 2'h1;
    d = nDone;
    issue(dsc_pkg::OP_WR_PIO, 28'h0000136, 8'h02);
    send(2);
    waitIrq();
    waitDone(d + 2);
    check("sectors tried", nDone, d + 2);
    check("wce cleared", wceOut, 1'b0);
    m = nMed;
    issue(dsc_pkg::OP_RD_PIO, 28'h00001f4, 8'h01);
    waitIrq();
    check("refused err", endStatus.err, 1'b1);
    check("refused lba", endStatus.lba, 28'h0000136);
    check("not executed", nMed, m);
    wcEnReq = 1'b1;
    @(negedge clk);
    wcEnReq = 1'b0;
    repeat (2) @(negedge clk);
    check("wce set", wceOut, 1'b1);
    errMode = 2'h1;
    d = nDone;
    issue(dsc_pkg::OP_WR_PIO, 28'h0000140, 8'h01);
    send(1);
    waitIrq();
    waitDone(d + 1);
    issue(dsc_pkg::OP_WR_DMA, 28'h0000150, 8'h01);
    send(1);
    waitIrq();
    check("write then err", endStatus.err, 1'b1);
    check("write then lba", endStatus.lba, 28'h0000140);
    check("write recorded", nDone, d + 2);
    wcEnReq = 1'b1;
    delay = 16'h0014;
    @(negedge clk);
    wcEnReq = 1'b0;
    issue(dsc_pkg::OP_WR_DMA, 28'h0000190, 8'h01);
    send(1);
    waitIrq();
    wcDisReq = 1'b1;
    @(negedge clk);
    wcDisReq = 1'b0;
    check("wce held", wceOut, 1'b1);
    waitDone(d + 3);
    repeat (2) @(negedge clk);
    check("wce off", wceOut, 1'b0);
  endtask : t_error
  initial
  begin
    repeat (6) @(negedge clk);
    resetn = 1'b1;
    check("wceOut", wceOut, dsc_pkg::WCE_RESET);
    check("irq", irq, 1'b0);
    t_post();
    t_drain();
    t_partial();
    t_error();
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
